/* File: include/vtm_pkg.sv */
/*
   Shared constants for the supply voltage trip monitor: register offsets,
   control field positions, reset values, bus responses and monitor states.
   Assumes a 32-bit register bus with byte addresses of 12 bits.
*/
package vtm_pkg;
   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFS = 12'h114;
   localparam logic [11:0] STAT_OFS = 12'h118;
   localparam logic [11:0] MASK_OFS = 12'h11c;
   // -------------------------------------------------------------
   // control fields
   // -------------------------------------------------------------
   localparam int PWR_EN_BIT = 15;
   localparam int IDLE_STOP_BIT = 13;
   localparam int DIR_BIT = 11;
   localparam int BG_STABLE_BIT = 10;
   localparam int IR_STABLE_BIT = 9;
   localparam int EVT_LIVE_BIT = 8;
   localparam int CMP_EN_BIT = 7;
   localparam int LVL_MSB = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'ha88f;
   localparam logic [3:0] LVL_EXT_SENSE = 4'hf;
   localparam logic [3:0] LVL_FIRST_VALID = 4'h5;
   // -------------------------------------------------------------
   // status, mask and bus
   // -------------------------------------------------------------
   localparam int STS_W = 2;
   localparam int STS_TRIP_BIT = 0;
   localparam int STS_REF_BIT = 1;
   localparam logic [1:0] STS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int INSTR_DIV = 2;
   typedef enum logic [1:0] {
      MON_OFF = 2'b00,
      MON_REF_WAIT = 2'b01,
      MON_ARMED = 2'b11,
      MON_HALTED = 2'b10
   } mon_state_e;
endpackage

/* File: include/vtm_mon_if.sv */
/*
   Carrier between the register side of the trip monitor and its event core.
   Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
interface vtm_mon_if;
   logic operative;
   logic trip_direction;
   logic level_valid;
   logic event_live_status;
   modport ctl (
      output operative,
      output trip_direction,
      output level_valid,
      input event_live_status
   );
   modport core (
      input operative,
      input trip_direction,
      input level_valid,
      output event_live_status
   );
endinterface

/* File: logic/vtm_instr_div.sv */
/*
   Instruction cycle enable: one-cycle pulse every DIV system clocks.
   Assumes a synchronous active-low reset.
*/
`timescale 1ns/1ps
module vtm_instr_div #(
   parameter int DIV = vtm_pkg::INSTR_DIV
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   output logic instr_en_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [CW-1:0] cnt_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         cnt_reg <= '0;
         instr_en_o <= 1'b0;
      end else if (cnt_reg == CW'(DIV - 1)) begin
         cnt_reg <= '0;
         instr_en_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         instr_en_o <= 1'b0;
      end
   end
endmodule

/* File: logic/vtm_event_core.sv */
/*
   Event core: synchronises the analog comparator result and evaluates the
   trip condition once per instruction cycle.
   Assumes the comparator reports 1 while the monitored voltage is at or
   above the selected trip point.
*/
`timescale 1ns/1ps
module vtm_event_core (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic instr_en_i,
   input wire logic comp_above_i,
   vtm_mon_if.core mon
);
   logic sync1_reg;
   logic sync2_reg;

   // -------------------------------------------------------------
   // comparator synchroniser
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= comp_above_i;
         sync2_reg <= sync1_reg;
      end
   end

   // -------------------------------------------------------------
   // trip evaluation
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         mon.event_live_status <= 1'b0;
      end else if (instr_en_i) begin
         if (mon.operative && mon.level_valid) begin
            mon.event_live_status <= mon.trip_direction ? sync2_reg : !sync2_reg;
         end else begin
            mon.event_live_status <= 1'b0;
         end
      end
   end
endmodule

/* File: logic/voltage_trip_monitor_ctrl.sv */
/*
   Supply voltage trip monitor control: AXI4-Lite register slave, control
   register, monitor state machine, sticky interrupt status with mask.
   Assumes an analog comparator and reference block outside that take the
   enables and level code and return compare and stable indications,
   all synchronous to clk_sys_i except the comparator result.
*/
`timescale 1ns/1ps
module voltage_trip_monitor_ctrl #(
   parameter int INSTR_DIV = vtm_pkg::INSTR_DIV
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [11:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [11:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   input wire logic comp_above_i,
   input wire logic bandgap_stable_i,
   input wire logic intref_stable_i,
   input wire logic idle_mode_i,
   input wire logic brownout_reset_i,
   output logic detector_power_o,
   output logic comparator_on_o,
   output logic [3:0] trip_level_o,
   output logic ext_sense_select_o,
   output logic irq_o
);
   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic aw_held_reg;
   logic w_held_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic aw_held_next;
   logic w_held_next;
   logic bvalid_next;
   logic rvalid_next;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic [15:0] lane_mask;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_view;
   logic [vtm_pkg::STS_W-1:0] status_reg;
   logic [vtm_pkg::STS_W-1:0] mask_reg;
   logic [vtm_pkg::STS_W-1:0] sts_set;
   logic [vtm_pkg::STS_W-1:0] sts_clr;
   logic intref_prev_reg;
   logic halt_req;
   logic mon_on;
   logic instr_en;
   vtm_pkg::mon_state_e state_reg;
   vtm_pkg::mon_state_e state_next;
   vtm_mon_if mon ();

   // -------------------------------------------------------------
   // write channel
   // -------------------------------------------------------------
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_o;

   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      bvalid_next = bvalid_o;
      if (awvalid_i && awready_o) begin
         aw_held_next = 1'b1;
      end else if (wr_fire) begin
         aw_held_next = 1'b0;
      end
      if (wvalid_i && wready_o) begin
         w_held_next = 1'b1;
      end else if (wr_fire) begin
         w_held_next = 1'b0;
      end
      if (wr_fire) begin
         bvalid_next = 1'b1;
      end else if (bvalid_o && bready_i) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_o <= 1'b0;
         wready_o <= 1'b0;
         bvalid_o <= 1'b0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_o <= !aw_held_next && !bvalid_next;
         wready_o <= !w_held_next && !bvalid_next;
         bvalid_o <= bvalid_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_addr_reg <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_data_reg <= wdata_i;
            w_strb_reg <= wstrb_i;
         end
      end
   end

   // -------------------------------------------------------------
   // write address decode
   // -------------------------------------------------------------
   always_comb begin
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (aw_addr_reg[11:2] == vtm_pkg::CTRL_OFS[11:2]) begin
         wr_ctrl = wr_fire;
      end else if (aw_addr_reg[11:2] == vtm_pkg::STAT_OFS[11:2]) begin
         wr_stat = wr_fire;
      end else if (aw_addr_reg[11:2] == vtm_pkg::MASK_OFS[11:2]) begin
         wr_mask = wr_fire;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         bresp_o <= vtm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bresp_o <= (wr_ctrl || wr_stat || wr_mask) ? vtm_pkg::RESP_OKAY
                                                    : vtm_pkg::RESP_SLVERR;
      end
   end

   // -------------------------------------------------------------
   // control register
   // -------------------------------------------------------------
   assign lane_mask = vtm_pkg::CTRL_WMASK & {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ctrl_reg <= vtm_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         // stable and live bits are not stored: writes to them are dropped
         ctrl_reg <= (ctrl_reg & ~lane_mask) | (w_data_reg[15:0] & lane_mask);
      end
   end

   // live view: stored fields plus hardware flags, unused bits zero
   always_comb begin
      ctrl_view = ctrl_reg & vtm_pkg::CTRL_WMASK;
      ctrl_view[vtm_pkg::BG_STABLE_BIT] = bandgap_stable_i;
      ctrl_view[vtm_pkg::IR_STABLE_BIT] = intref_stable_i;
      ctrl_view[vtm_pkg::EVT_LIVE_BIT] = mon.event_live_status;
   end

   // -------------------------------------------------------------
   // monitor state machine
   // -------------------------------------------------------------
   assign mon_on = ctrl_reg[vtm_pkg::PWR_EN_BIT] && ctrl_reg[vtm_pkg::CMP_EN_BIT];
   assign halt_req = ctrl_reg[vtm_pkg::IDLE_STOP_BIT] && idle_mode_i;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         vtm_pkg::MON_OFF: begin
            if (mon_on) begin
               state_next = vtm_pkg::MON_REF_WAIT;
            end
         end
         vtm_pkg::MON_REF_WAIT: begin
            if (!mon_on) begin
               state_next = vtm_pkg::MON_OFF;
            end else if (halt_req) begin
               state_next = vtm_pkg::MON_HALTED;
            end else if (intref_stable_i) begin
               state_next = vtm_pkg::MON_ARMED;
            end
         end
         vtm_pkg::MON_ARMED: begin
            if (!mon_on) begin
               state_next = vtm_pkg::MON_OFF;
            end else if (halt_req) begin
               state_next = vtm_pkg::MON_HALTED;
            end else if (!intref_stable_i) begin
               state_next = vtm_pkg::MON_REF_WAIT;
            end
         end
         vtm_pkg::MON_HALTED: begin
            if (!mon_on) begin
               state_next = vtm_pkg::MON_OFF;
            end else if (!halt_req) begin
               state_next = vtm_pkg::MON_REF_WAIT;
            end
         end
         default: begin
            state_next = vtm_pkg::MON_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_reg <= vtm_pkg::MON_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------
   // event core
   // -------------------------------------------------------------
   assign mon.operative = mon_on && !halt_req;
   assign mon.trip_direction = ctrl_reg[vtm_pkg::DIR_BIT];
   // reserved codes never evaluate a trip
   assign mon.level_valid = ctrl_reg[vtm_pkg::LVL_MSB:0] >= vtm_pkg::LVL_FIRST_VALID;

   vtm_instr_div #(
      .DIV(INSTR_DIV)
   ) u_div (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .instr_en_o(instr_en)
   );

   vtm_event_core u_core (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .instr_en_i(instr_en),
      .comp_above_i(comp_above_i),
      .mon(mon.core)
   );

   // -------------------------------------------------------------
   // status, mask and interrupt
   // -------------------------------------------------------------
   always_comb begin
      sts_set = '0;
      // trip flag only while the reference is stable, or on brownout_reset_i
      sts_set[vtm_pkg::STS_TRIP_BIT] = (state_reg == vtm_pkg::MON_ARMED && intref_stable_i &&
                                        mon.event_live_status) || brownout_reset_i;
      sts_set[vtm_pkg::STS_REF_BIT] = mon_on && intref_stable_i && !intref_prev_reg;
      sts_clr = '0;
      if (wr_stat && w_strb_reg[0]) begin
         sts_clr = w_data_reg[vtm_pkg::STS_W-1:0];
         // clear ignored while the trip still holds
         if (mon.event_live_status) begin
            sts_clr[vtm_pkg::STS_TRIP_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         status_reg <= vtm_pkg::STS_RESET;
         intref_prev_reg <= 1'b0;
      end else begin
         // set wins over a same-cycle clear
         status_reg <= (status_reg & ~sts_clr) | sts_set;
         intref_prev_reg <= intref_stable_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         mask_reg <= vtm_pkg::MASK_RESET;
      end else if (wr_mask && w_strb_reg[0]) begin
         mask_reg <= w_data_reg[vtm_pkg::STS_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_reg & mask_reg);
      end
   end

   // -------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if (araddr_i[11:2] == vtm_pkg::CTRL_OFS[11:2]) begin
         rd_word[15:0] = ctrl_view;
      end else if (araddr_i[11:2] == vtm_pkg::STAT_OFS[11:2]) begin
         rd_word[vtm_pkg::STS_W-1:0] = status_reg;
      end else if (araddr_i[11:2] == vtm_pkg::MASK_OFS[11:2]) begin
         rd_word[vtm_pkg::STS_W-1:0] = mask_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_comb begin
      rvalid_next = rvalid_o;
      if (arvalid_i && arready_o) begin
         rvalid_next = 1'b1;
      end else if (rvalid_o && rready_i) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         rvalid_o <= 1'b0;
         arready_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
         rresp_o <= vtm_pkg::RESP_OKAY;
      end else begin
         rvalid_o <= rvalid_next;
         arready_o <= !rvalid_next;
         if (arvalid_i && arready_o) begin
            rdata_o <= rd_word;
            rresp_o <= rd_hit ? vtm_pkg::RESP_OKAY : vtm_pkg::RESP_SLVERR;
         end
      end
   end

   // -------------------------------------------------------------
   // analog side controls
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         detector_power_o <= 1'b0;
         comparator_on_o <= 1'b0;
         trip_level_o <= 4'h0;
         ext_sense_select_o <= 1'b0;
      end else begin
         detector_power_o <= ctrl_reg[vtm_pkg::PWR_EN_BIT];
         // comparator idles while halted to save current
         comparator_on_o <= mon.operative;
         trip_level_o <= ctrl_reg[vtm_pkg::LVL_MSB:0];
         ext_sense_select_o <= ctrl_reg[vtm_pkg::LVL_MSB:0] == vtm_pkg::LVL_EXT_SENSE;
      end
   end
endmodule

/* File: bench/vtm_analog_model.sv */
/*
   Behavioural far side of the trip monitor: comparator and references.
   Assumes the bench sets the supply condition and reference upsets.
*/
`timescale 1ns/1ps
module vtm_analog_model #(
   parameter int SETTLE = 4
) (
   input wire logic clk_sys_i,
   input wire logic power_i,
   input wire logic cmp_on_i,
   input wire logic above_i,
   input wire logic unstable_i,
   output logic comp_above_o,
   output logic bandgap_stable_o,
   output logic intref_stable_o
);
   // ---------------------------------------------
   // settling and comparator
   // ---------------------------------------------
   int settle_cnt = 0;
   logic toggle = 1'b0;
   always @(posedge clk_sys_i) begin
      settle_cnt <= power_i ? settle_cnt + int'(settle_cnt < 15) : 0;
      toggle <= ~toggle;
   end
   assign bandgap_stable_o = settle_cnt >= SETTLE;
   assign intref_stable_o = settle_cnt >= SETTLE + 2 && !unstable_i;
   // comparator off: output wanders, not a held value
   assign comp_above_o = cmp_on_i ? above_i : toggle;
endmodule

/* File: bench/vtm_properties.sv */
/*
   Port-level assertions for the trip monitor control block.
   Assumes binding onto the top module, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module vtm_properties #(
   parameter int INSTR_DIV = 2
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic [1:0] bresp_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [11:0] araddr_i,
   input wire logic arvalid_i,
   input wire logic arready_o,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] rresp_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   input wire logic detector_power_o,
   input wire logic comparator_on_o,
   input wire logic [3:0] trip_level_o,
   input wire logic ext_sense_select_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   sequence wr_take;
      awvalid_i && awready_o && wvalid_i && wready_o;
   endsequence
   sequence rd_take;
      arvalid_i && arready_o;
   endsequence
   reset_quiet_a:
   assert property (disable iff (1'b0) !resetn_i |=> !bvalid_o && !rvalid_o && !irq_o
      && !detector_power_o) else $error("outputs not cleared by reset");
   cmp_gate_a:
   assert property (comparator_on_o |-> detector_power_o) else $error("comparator without power");
   ext_sel_a:
   assert property (ext_sense_select_o == (trip_level_o == 4'hf)) else $error("sense select");
   b_hold_a:
   assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o)) else $error("b hold");
   r_hold_a:
   assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o)) else $error("r hold");
   wr_answer_a:
   assert property (wr_take |-> ##2 bvalid_o) else $error("write answer late");
   rd_answer_a:
   assert property (rd_take |=> rvalid_o) else $error("read answer late");
   rd_refuse_a:
   assert property (rvalid_o |-> !arready_o) else $error("read taken while busy");
   wr_refuse_a:
   assert property (bvalid_o |-> !awready_o && !wready_o) else $error("write taken while busy");
   rd_unmapped_a:
   assert property (rd_take ##0 !(araddr_i inside {12'h114, 12'h118, 12'h11c}) |=>
      rresp_o == 2'h2 && rdata_o == 32'h0) else $error("unmapped read");
   ctrl_unused_a:
   assert property (rd_take ##0 araddr_i == 12'h114 |=> (rdata_o & ~32'h0000af8f) == 32'h0)
      else $error("unused control bits set");
endmodule
bind voltage_trip_monitor_ctrl vtm_properties #(.INSTR_DIV(INSTR_DIV)) i_vtm_properties (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
   .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
   .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
   .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
   .detector_power_o(detector_power_o), .comparator_on_o(comparator_on_o),
   .trip_level_o(trip_level_o), .ext_sense_select_o(ext_sense_select_o), .irq_o(irq_o)
);

/* File: bench/voltage_trip_monitor_ctrl_tb_top.sv */
/*
   Self-checking bench for the trip monitor control block.
   Assumes the analog model on the far side and an AXI4-Lite master here.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module voltage_trip_monitor_ctrl_tb_top;
   logic clk_sys_i = 0, resetn_i = 0, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
   logic arvalid_i = 0, rready_i = 0, idle_mode_i = 0, brownout_reset_i = 0;
   logic above = 0, unstable = 0, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic comp_above, bg_stable, ir_stable, detector_power_o, comparator_on_o, ext_sel, irq_o;
   logic [11:0] awaddr_i = 0, araddr_i = 0;
   logic [31:0] wdata_i = 0, rdata_o;
   logic [1:0] bresp_o, rresp_o, resp;
   logic [3:0] trip_level_o;
   int miscompares = 0, cmp_count = 0;
   typedef struct {logic [11:0] a; logic [31:0] w; logic [1:0] r; logic [31:0] d;} row_s;
   row_s rows [6] = '{'{12'h114, 32'h0000_7f7f, 2'h0, 32'h0000_280f},
      '{12'h114, 32'hffff_0080, 2'h0, 32'h0000_0080}, '{12'h11c, 32'hffff_ffff, 2'h0, 32'h3},
      '{12'h11c, 32'h0, 2'h0, 32'h0}, '{12'h120, 32'hffff, 2'h2, 32'h0},
      '{12'h000, 32'hffff, 2'h2, 32'h0}};
   always #12.5 clk_sys_i = ~clk_sys_i;
   voltage_trip_monitor_ctrl i_voltage_trip_monitor_ctrl (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
      .wdata_i(wdata_i), .wstrb_i(4'hf), .wvalid_i(wvalid_i), .wready_o(wready_o),
      .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i),
      .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .rvalid_o(rvalid_o), .rready_i(rready_i), .comp_above_i(comp_above),
      .bandgap_stable_i(bg_stable), .intref_stable_i(ir_stable), .idle_mode_i(idle_mode_i),
      .brownout_reset_i(brownout_reset_i), .detector_power_o(detector_power_o),
      .comparator_on_o(comparator_on_o), .trip_level_o(trip_level_o),
      .ext_sense_select_o(ext_sel), .irq_o(irq_o));
   vtm_analog_model i_vtm_analog_model (.clk_sys_i(clk_sys_i), .power_i(detector_power_o),
      .cmp_on_i(comparator_on_o), .above_i(above), .unstable_i(unstable),
      .comp_above_o(comp_above), .bandgap_stable_o(bg_stable), .intref_stable_o(ir_stable));
   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic guard(input int n);
      if (n >= 40) begin
         miscompares++;
         $display("[ERR] handshake exp answer got none");
         finish_test();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw = 1, w = 1;
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      for (n = 0; n < 40 && (aw || w); n++) begin
         @(posedge clk_sys_i);
         aw = aw && !awready_o;
         w = w && !wready_o;
         awvalid_i <= aw;
         wvalid_i <= w;
      end
      guard(n);
      for (n = 0; n < 40 && !bvalid_o; n++) @(posedge clk_sys_i);
      guard(n);
      bready_i <= 1'b1;
      @(posedge clk_sys_i);
      r = bresp_o;
      bready_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar = 1;
      araddr_i <= a;
      arvalid_i <= 1'b1;
      for (n = 0; n < 40 && ar; n++) begin
         @(posedge clk_sys_i);
         ar = !arready_o;
         arvalid_i <= ar;
      end
      guard(n);
      for (n = 0; n < 40 && !rvalid_o; n++) @(posedge clk_sys_i);
      guard(n);
      rready_i <= 1'b1;
      @(posedge clk_sys_i);
      d = rdata_o;
      r = rresp_o;
      rready_i <= 1'b0;
   endtask
   task automatic rd_chk(string s, logic [11:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(s, e, d)
      `CHK(s, er, r)
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      tick(2);
      resetn_i <= 1'b1;
      tick(1);
      for (int i = 0; i < 6; i++) begin
         wr(rows[i].a, rows[i].w, resp);
         `CHK("bresp", rows[i].r, resp)
         rd_chk("row", rows[i].a, rows[i].d, rows[i].r);
      end
      `CHK("cmp_gate", 1'b0, comparator_on_o)
      $display("test rows done");
      wr(12'h114, 32'h0000_888a, resp);
      tick(10);
      `CHK("power", 1'b1, detector_power_o)
      `CHK("cmp_on", 1'b1, comparator_on_o)
      `CHK("level", 4'ha, trip_level_o)
      rd_chk("stable", 12'h114, 32'h0000_8e8a);
      rd_chk("ref_evt", 12'h118, 32'h2);
      `CHK("masked", 1'b0, irq_o)
      wr(12'h11c, 32'h3, resp);
      `CHK("unmasked", 1'b1, irq_o)
      wr(12'h118, 32'h2, resp);
      `CHK("irq_clr", 1'b0, irq_o)
      above <= 1'b1;
      tick(10);
      rd_chk("live_up", 12'h114, 32'h0000_8f8a);
      `CHK("trip_irq", 1'b1, irq_o)
      unstable <= 1'b1;
      tick(2);
      wr(12'h118, 32'h1, resp);
      rd_chk("no_clear", 12'h118, 32'h1);
      unstable <= 1'b0;
      above <= 1'b0;
      tick(10);
      wr(12'h118, 32'h3, resp);
      rd_chk("clear", 12'h118, 32'h0);
      $display("test trip up done");
      wr(12'h114, 32'h0000_808a, resp);
      tick(10);
      rd_chk("live_dn", 12'h114, 32'h0000_878a);
      wr(12'h114, 32'h0000_800a, resp);
      tick(10);
      rd_chk("cmp_off", 12'h114, 32'h0000_860a);
      idle_mode_i <= 1'b1;
      wr(12'h114, 32'h0000_a08a, resp);
      tick(10);
      `CHK("idle_stop", 1'b0, comparator_on_o)
      rd_chk("idle_live", 12'h114, 32'h0000_a68a);
      wr(12'h114, 32'h0000_808a, resp);
      tick(10);
      `CHK("idle_run", 1'b1, comparator_on_o)
      idle_mode_i <= 1'b0;
      wr(12'h114, 32'h0000_8084, resp);
      tick(10);
      rd_chk("reserved", 12'h114, 32'h0000_8684);
      wr(12'h114, 32'h0000_808f, resp);
      `CHK("ext_sel", 1'b1, ext_sel)
      $display("test modes done");
      wr(12'h114, 32'h0, resp);
      unstable <= 1'b1;
      tick(5);
      wr(12'h118, 32'h3, resp);
      wr(12'h114, 32'h0000_808a, resp);
      tick(10);
      rd_chk("unstable", 12'h114, 32'h0000_858a);
      rd_chk("no_flag", 12'h118, 32'h0);
      wr(12'h114, 32'h0, resp);
      unstable <= 1'b0;
      tick(5);
      brownout_reset_i <= 1'b1;
      tick(1);
      brownout_reset_i <= 1'b0;
      tick(3);
      rd_chk("brownout", 12'h118, 32'h1);
      wr(12'h118, 32'h1, resp);
      rd_chk("first_use", 12'h118, 32'h0);
      $display("test faults done");
      resetn_i <= 1'b0;
      tick(2);
      resetn_i <= 1'b1;
      tick(1);
      rd_chk("rst_ctrl", 12'h114, 32'h0);
      rd_chk("rst_mask", 12'h11c, 32'h0);
      $display("test reset done");
      finish_test();
   end
endmodule
